/* File: src/mpg_timer_map.svh */
// Constants of the multi-pulse timer and trip control block.
// Assumes an APB master on pclk and 32-bit aligned words.
`ifndef MPG_TIMER_MAP_SVH
`define MPG_TIMER_MAP_SVH
`define OFS_WOCH       12'h000
`define OFS_TCS        12'h004
`define OFS_CMP        12'h008
`define OFS_LATCH      12'h00c
`define OFS_NCC        12'h010
`define OFS_COUNT      12'h014
`define OFS_PDATA      12'h018
`define BIT_TRIP_EN    7
`define BIT_TRIP_FLAG  6
`define BIT_FILT_EN    5
`define BIT_WT_FLAG    1
`define BIT_WT_IE      0
`define BIT_RUN        0
`define BIT_SOFT_CLR   1
`define BIT_CLR_SRC    2
`define BIT_CC_IE      5
`define BIT_CC_FLAG    6
`define RST_WOCH       8'h00
`define RST_COUNT      16'h0000
`define RST_CMP        16'hffff
`define FILT_MIN_BITS  3'h2
`define PRESC_W        8
`endif

/* File: src/mpg_timer_pkg.sv */
// Types of the multi-pulse timer and trip control block.
// Assumes mpg_timer_map.svh supplies the numbers.
package mpg_timer_pkg;
  typedef enum logic [1:0] {
    apb_idle, apb_wait
  } apb_state_t;
  typedef logic [15:0] count_t;
endpackage : mpg_timer_pkg

/* File: src/multipulse_timer_trip_control.sv */
// 16-bit timer with clear sources, count latch and trip input control.
// Assumes an APB master on pclk; event inputs are pclk pulses.
`timescale 1ns/1ns
`default_nettype none
`include "mpg_timer_map.svh"
module multipulse_timer_trip_control
  import mpg_timer_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        rmw_access,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        trip_input,
  input  wire logic        clock_stopped,
  input  wire logic        write_timing_evt,
  input  wire logic        position_evt,
  input  wire logic        position_irq_req,
  input  wire logic [5:0]  wave_in,
  input  wire logic [5:0]  wave_enable,
  output var  logic [5:0]  waveform_out_x,
  output var  logic        irq_trip,
  output var  logic        irq_clear_wt,
  output var  logic        irq_match_pd
);

  function automatic logic [5:0] filt_limit(input logic [1:0] sel);
    filt_limit = 6'((32'd1 << (32'(sel) + 32'(`FILT_MIN_BITS))) - 32'd1);
  endfunction : filt_limit

  function automatic logic [`PRESC_W-1:0] presc_mask(input logic [1:0] sel);
    logic [31:0] m;
    m = (32'd1 << (32'(sel) + 32'd1)) - 32'd1;
    presc_mask = m[`PRESC_W-1:0];
  endfunction : presc_mask

  logic [7:0]  woch;
  logic        run;
  logic        clr_src;
  logic        cc_ie;
  logic        cc_flag;
  logic [1:0]  presc_sel;
  count_t      count;
  count_t      cmp;
  count_t      latch;
  logic [1:0]  filt_sel;
  logic [5:0]  port_data_x;
  logic        cmp_armed;
  logic        clr_pend;
  logic [`PRESC_W-1:0] presc;
  logic        tick;
  logic        trip_s1;
  logic        trip_s2;
  logic        trip_filt;
  logic [5:0]  filt_cnt;
  logic        trip_ok;
  logic        trip_ok_d;
  logic        acc;
  logic        wr;
  logic [31:0] rd_word;
  logic        mapped;
  logic        match;
  logic        trip_fall;

  assign acc = psel & penable & pready;
  assign wr  = acc & pwrite;

  // No wait state; every bus output comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite) begin
        prdata <= rd_word;
      end
    end
  end

  always_comb begin
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      `OFS_WOCH: begin
        rd_word[7:0] = woch;
        if (rmw_access) begin
          rd_word[`BIT_TRIP_FLAG] = 1'b1;
          rd_word[`BIT_WT_FLAG]   = 1'b1;
        end
      end
      `OFS_TCS: begin
        rd_word[`BIT_RUN]     = run;
        rd_word[`BIT_CLR_SRC] = clr_src;
        rd_word[4:3]          = presc_sel;
        rd_word[`BIT_CC_IE]   = cc_ie;
        rd_word[`BIT_CC_FLAG] = cc_flag | rmw_access;
      end
      `OFS_CMP:   rd_word[15:0] = cmp;
      `OFS_LATCH: rd_word[15:0] = latch;
      `OFS_NCC:   rd_word[1:0]  = filt_sel;
      `OFS_COUNT: rd_word[15:0] = count;
      `OFS_PDATA: rd_word[5:0]  = port_data_x;
      default:    mapped = 1'b0;
    endcase
  end

  // Upper output control register; a hardware set wins over a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      woch <= `RST_WOCH;
    end else begin
      if (wr && paddr == `OFS_WOCH) begin
        woch[7]   <= pwdata[`BIT_TRIP_EN];
        woch[5:2] <= pwdata[5:2];
        woch[0]   <= pwdata[`BIT_WT_IE];
      end
      if (trip_fall) begin
        woch[6] <= 1'b1;
      end else if (wr && paddr == `OFS_WOCH && !pwdata[`BIT_TRIP_FLAG]) begin
        woch[6] <= 1'b0;
      end
      if (write_timing_evt) begin
        woch[1] <= 1'b1;
      end else if (wr && paddr == `OFS_WOCH && !pwdata[`BIT_WT_FLAG]) begin
        woch[1] <= 1'b0;
      end
    end
  end

  // Compare clear flag; a match wins over a simultaneous clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cc_flag <= 1'b0;
    end else if (tick && match) begin
      cc_flag <= 1'b1;
    end else if (wr && paddr == `OFS_TCS && !pwdata[`BIT_CC_FLAG]) begin
      cc_flag <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run         <= 1'b0;
      clr_src     <= 1'b0;
      presc_sel   <= 2'h0;
      cc_ie       <= 1'b0;
      cmp         <= `RST_CMP;
      filt_sel    <= 2'h0;
      port_data_x <= 6'h00;
    end else if (wr) begin
      case (paddr)
        `OFS_TCS: begin
          run       <= pwdata[`BIT_RUN];
          clr_src   <= pwdata[`BIT_CLR_SRC];
          presc_sel <= pwdata[4:3];
          cc_ie     <= pwdata[`BIT_CC_IE];
        end
        `OFS_CMP:   cmp         <= pwdata[15:0];
        `OFS_NCC:   filt_sel    <= pwdata[1:0];
        `OFS_PDATA: port_data_x <= pwdata[5:0];
        default: ;
      endcase
    end
  end

  // Prescaler: tick every 2^(sel+1) clocks while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc <= '0;
    end else if (!run) begin
      presc <= '0;
    end else begin
      presc <= presc + 1'b1;
    end
  end
  assign tick = run && ((presc & presc_mask(presc_sel)) == presc_mask(presc_sel));

  // A compare value loaded equal to the count waits for the next pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_armed <= 1'b1;
    end else if (wr && paddr == `OFS_CMP && pwdata[15:0] == count) begin
      cmp_armed <= 1'b0;
    end else if (count != cmp) begin
      cmp_armed <= 1'b1;
    end
  end
  assign match = cmp_armed && count == cmp;

  // Clears other than reset wait for the next count tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clr_pend <= 1'b0;
    end else if ((wr && paddr == `OFS_TCS && pwdata[`BIT_SOFT_CLR] && run)
                 || (!clr_src && write_timing_evt) || (clr_src && position_evt)) begin
      clr_pend <= 1'b1;
    end else if (tick) begin
      clr_pend <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= `RST_COUNT;
    end else if (tick) begin
      if (clr_pend || match) begin
        count <= `RST_COUNT;
      end else begin
        count <= count + 16'h0001;
      end
    end
  end

  // Each restart copies the count for speed measurement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch <= `RST_COUNT;
    end else if (wr && paddr == `OFS_TCS && pwdata[`BIT_RUN] && !run) begin
      latch <= count;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_s1 <= 1'b1;
      trip_s2 <= 1'b1;
    end else begin
      trip_s1 <= trip_input;
      trip_s2 <= trip_s1;
    end
  end

  // Level must hold for 2^(sel+2) clocks before the filter accepts it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_cnt  <= 6'h00;
      trip_filt <= 1'b1;
    end else if (clock_stopped) begin
      filt_cnt <= 6'h00;
    end else if (trip_s2 == trip_filt) begin
      filt_cnt <= 6'h00;
    end else if (filt_cnt == filt_limit(filt_sel)) begin
      trip_filt <= trip_s2;
      filt_cnt  <= 6'h00;
    end else begin
      filt_cnt <= filt_cnt + 6'h01;
    end
  end

  assign trip_ok   = woch[`BIT_FILT_EN] ? trip_filt : trip_s2;
  assign trip_fall = woch[`BIT_TRIP_EN] && trip_ok_d && !trip_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip_ok_d <= 1'b1;
    end else begin
      trip_ok_d <= trip_ok;
    end
  end

  // Enabled outputs take their inactive level while trip is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waveform_out_x <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (woch[`BIT_TRIP_EN] && !trip_ok && wave_enable[i]) begin
          waveform_out_x[i] <= port_data_x[i];
        end else begin
          waveform_out_x[i] <= wave_in[i];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_trip     <= 1'b0;
      irq_clear_wt <= 1'b0;
      irq_match_pd <= 1'b0;
    end else begin
      irq_trip     <= woch[`BIT_TRIP_FLAG];
      irq_clear_wt <= (cc_flag & cc_ie) | (woch[1] & woch[0]);
      irq_match_pd <= (match & cc_ie) | position_irq_req;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_restart;
    wr && paddr == `OFS_TCS && pwdata[`BIT_RUN] && !run;
  endsequence
  sequence s_trip_drop;
    woch[`BIT_TRIP_EN] && trip_ok_d && !trip_ok;
  endsequence

  chk_overflow_wrap: assert property (
    tick && !clr_pend && !match && count == 16'hffff |=> count == 16'h0000 && !$rose(cc_flag))
    else $error("overflow did not wrap");
  chk_cmp_clear: assert property (
    tick && match |=> count == 16'h0000 && cc_flag)
    else $error("compare match did not clear");
  chk_clear_on_tick: assert property (
    clr_pend && !tick |=> count == $past(count))
    else $error("clear not aligned to tick");
  chk_count_step: assert property (
    tick && !clr_pend && !match |=> count == $past(count) + 16'h0001)
    else $error("count did not step");
  chk_latch_restart: assert property (
    s_restart |=> latch == $past(count))
    else $error("restart did not latch count");
  chk_latch_hold: assert property (
    !(wr && paddr == `OFS_TCS && pwdata[`BIT_RUN] && !run) |=> latch == $past(latch))
    else $error("latch changed without restart");
  chk_equal_load: assert property (
    wr && paddr == `OFS_CMP && pwdata[15:0] == count |=> !match)
    else $error("equal load matched at once");
  chk_trip_flag: assert property (
    s_trip_drop |=> woch[`BIT_TRIP_FLAG] ##1 irq_trip)
    else $error("trip edge lost");
  chk_trip_force: assert property (
    woch[`BIT_TRIP_EN] && !trip_ok && wave_enable[0] |=> waveform_out_x[0] == $past(port_data_x[0]))
    else $error("output not forced");
  chk_filter_hold: assert property (
    clock_stopped && woch[`BIT_FILT_EN] |=> $stable(trip_filt))
    else $error("filter moved while stopped");
  chk_filter_len: assert property (
    woch[`BIT_FILT_EN] && $changed(trip_filt) |-> $past(filt_cnt) == filt_limit($past(filt_sel)))
    else $error("filter length wrong");
  chk_soft_clear: assert property (
    wr && paddr == `OFS_TCS && pwdata[`BIT_SOFT_CLR] && run |=> clr_pend)
    else $error("soft clear not taken");
  chk_clear_source: assert property (
    (!clr_src && write_timing_evt) || (clr_src && position_evt) |=> clr_pend)
    else $error("clear source event lost");
  chk_flag_clear: assert property (
    wr && paddr == `OFS_WOCH && !pwdata[`BIT_TRIP_FLAG] && !trip_fall |=> !woch[`BIT_TRIP_FLAG])
    else $error("trip flag not cleared");
  chk_out_pass: assert property (
    !(woch[`BIT_TRIP_EN] && !trip_ok) |=> waveform_out_x == $past(wave_in))
    else $error("output altered without trip");

endmodule : multipulse_timer_trip_control
`default_nettype wire

/* File: verification/trip_source.sv */
// Model of the power stage fault line feeding the trip input.
// Assumes the bench changes active just after pclk edges.
`timescale 1ns/1ns
`default_nettype none
module trip_source (
  input  wire logic active,
  output wire logic trip_line
);
  // Active low fault; a released line sits at its pull-up level
  assign trip_line = active ? 1'b0 : 1'b1;
endmodule : trip_source
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the timer and trip control block.
// Assumes the block answers APB with pready and the trip line is modelled apart.
`timescale 1ns/1ns
`default_nettype none
`include "mpg_timer_map.svh"
module tb;
  import mpg_timer_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, rmw_access, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, c;
  logic        trip, trip_input, clock_stopped, wte, pev, irq_trip, irq_clear_wt, err, pirq, irq_match_pd;
  logic [5:0]  wave_in, wave_enable, waveform_out_x;
  int          failures, samples_checked;
  multipulse_timer_trip_control multipulse_timer_trip_control_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .rmw_access(rmw_access), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trip_input(trip_input), .clock_stopped(clock_stopped),
    .write_timing_evt(wte), .position_evt(pev), .position_irq_req(pirq), .wave_in(wave_in),
    .wave_enable(wave_enable), .waveform_out_x(waveform_out_x), .irq_trip(irq_trip),
    .irq_clear_wt(irq_clear_wt), .irq_match_pd(irq_match_pd));
  trip_source trip_source_inst (.active(trip), .trip_line(trip_input));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One APB transfer, held until pready; whole 32-bit word per register
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic r);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; rmw_access <= r; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0; rmw_access <= 1'b0;
    @(posedge pclk);
  endtask : acc
  task automatic pulse(input logic pos);
    if (pos) pev <= 1'b1;
    else wte <= 1'b1;
    @(posedge pclk);
    pev <= 1'b0;
    wte <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : pulse
  task automatic hold_trip(input int n, input logic [5:0] e, input string nm);
    trip <= 1'b1;
    repeat (n) @(posedge pclk);
    chk(nm, {26'h0, waveform_out_x}, {26'h0, e});
    trip <= 1'b0;
    repeat (45) @(posedge pclk);
  endtask : hold_trip
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    end_of_test();
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    rmw_access = 1'b0; trip = 1'b0; clock_stopped = 1'b0; wte = 1'b0; pev = 1'b0; pirq = 1'b0;
    wave_in = 6'h15; wave_enable = 6'h3f;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    acc(0, `OFS_WOCH, 0, 0); chk("woch reset", q, 32'h0);
    acc(0, `OFS_CMP, 0, 0); chk("cmp reset", q, 32'h0000ffff);
    acc(0, 12'h040, 0, 0); chk("unmapped err", {31'h0, err}, 32'h1);
    acc(1, `OFS_TCS, 32'h1, 0); repeat (40) @(posedge pclk);
    acc(0, `OFS_COUNT, 0, 0); chk("count runs", {31'h0, q inside {[10:30]}}, 32'h1);
    pulse(1'b0); acc(0, `OFS_COUNT, 0, 0); chk("wt clear", {31'h0, q < 6}, 32'h1);
    acc(1, `OFS_TCS, 32'h5, 0); repeat (20) @(posedge pclk); pulse(1'b0);
    acc(0, `OFS_COUNT, 0, 0); chk("wt ignored", {31'h0, q > 8}, 32'h1);
    pulse(1'b1); acc(0, `OFS_COUNT, 0, 0); chk("pos clear", {31'h0, q < 6}, 32'h1);
    repeat (30) @(posedge pclk); acc(1, `OFS_TCS, 32'h7, 0);
    acc(0, `OFS_COUNT, 0, 0); chk("soft clear", {31'h0, q < 4}, 32'h1);
    acc(1, `OFS_TCS, 32'h0, 0); acc(0, `OFS_COUNT, 0, 0); c = q;
    repeat (6) @(posedge pclk); acc(0, `OFS_COUNT, 0, 0); chk("stopped", q, c);
    acc(1, `OFS_TCS, 32'h1, 0); acc(0, `OFS_LATCH, 0, 0); chk("latch", q, c);
    repeat (20) @(posedge pclk); acc(0, `OFS_LATCH, 0, 0); chk("latch held", q, c);
    acc(1, `OFS_TCS, 32'h0, 0);
    acc(1, `OFS_CMP, 32'h5, 0); acc(1, `OFS_TCS, 32'h21, 0); acc(1, `OFS_TCS, 32'h23, 0);
    repeat (30) @(posedge pclk);
    acc(0, `OFS_COUNT, 0, 0); chk("cmp clear", {31'h0, q <= 5}, 32'h1);
    chk("cmp irq", {31'h0, irq_clear_wt}, 32'h1);
    acc(1, `OFS_PDATA, 32'h2a, 0); acc(1, `OFS_WOCH, 32'h80, 0);
    chk("out pass", {26'h0, waveform_out_x}, 32'h15);
    trip <= 1'b1; repeat (6) @(posedge pclk);
    chk("out forced", {26'h0, waveform_out_x}, 32'h2a);
    chk("trip irq", {31'h0, irq_trip}, 32'h1);
    acc(0, `OFS_WOCH, 0, 0); chk("flag set", q, 32'hc0);
    acc(1, `OFS_WOCH, 32'hc0, 0); acc(0, `OFS_WOCH, 0, 0); chk("one no effect", q, 32'hc0);
    acc(1, `OFS_WOCH, 32'h80, 0); acc(0, `OFS_WOCH, 0, 0); chk("flag clr", q, 32'h80);
    acc(0, `OFS_WOCH, 0, 1); chk("rmw one", q, 32'hc2);
    trip <= 1'b0; repeat (6) @(posedge pclk);
    chk("out free", {26'h0, waveform_out_x}, 32'h15);
    acc(1, `OFS_NCC, 32'h3, 0); acc(1, `OFS_WOCH, 32'ha0, 0);
    hold_trip(20, 6'h15, "glitch");
    hold_trip(40, 6'h2a, "filtered");
    clock_stopped <= 1'b1;
    hold_trip(50, 6'h15, "clk stop");
    clock_stopped <= 1'b0;
    acc(1, `OFS_WOCH, 32'h00, 0);
    hold_trip(40, 6'h15, "disabled");
    acc(1, `OFS_TCS, 32'h1, 0); pirq <= 1'b1; repeat (2) @(posedge pclk);
    chk("pd irq", {31'h0, irq_match_pd}, 32'h1);
    pirq <= 1'b0; repeat (2) @(posedge pclk);
    chk("pd irq off", {31'h0, irq_match_pd}, 32'h0);
    acc(1, `OFS_CMP, 32'hffff, 0); repeat (30) @(posedge pclk); acc(1, `OFS_TCS, 32'h0, 0);
    acc(0, `OFS_COUNT, 0, 0); c = q; acc(1, `OFS_CMP, c, 0); acc(1, `OFS_TCS, 32'h1, 0);
    repeat (10) @(posedge pclk); acc(0, `OFS_COUNT, 0, 0);
    chk("equal skip", {31'h0, q > c}, 32'h1);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
